// >>> cbp_pkg.sv
// constants, types and register map for the configuration stream parser
package cbp_pkg;

  // stream field patterns
  localparam logic [3:0]  PRE_SER    = 4'h2;
  localparam logic [7:0]  PRE_EXP    = 8'hf2;
  localparam logic [7:0]  START_EXP  = 8'hfe;
  localparam logic [3:0]  CHK_SER    = 4'h6;
  localparam logic [7:0]  CHK_EXP    = 8'hd2;
  localparam logic [7:0]  POST_SER   = 8'h7f;

  // field lengths and counts
  localparam logic [15:0] LEN_BITS_LAST  = 16'h0017;
  localparam logic [15:0] EXP_LEN_LAST   = 16'h0002;
  localparam logic [15:0] EXP_SEP_LAST   = 16'h0002;
  localparam logic [15:0] CHK_BITS_LAST  = 16'h0003;
  localparam logic [15:0] POST_BITS_LAST = 16'h0007;
  localparam logic [2:0]  STARTUP_LAST   = 3'h3;
  localparam int          LAST_DATA_BITS = 7;
  localparam logic [3:0]  RB_CRC_LAST    = 4'ha;

  // crc-16 ccitt
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'h0000;

  // master clock divider: half period of the configuration clock
  localparam int          CORE_CLK_NS   = 8;
  localparam int          CFG_CLK_MIN_NS = 80;
  localparam int          CFG_HALF_CYC  = (CFG_CLK_MIN_NS / 2 + CORE_CLK_NS - 1) / CORE_CLK_NS;

  // register offsets
  localparam logic [3:0]  OFS_CTRL   = 4'h0;
  localparam logic [3:0]  OFS_STATUS = 4'h4;
  localparam logic [3:0]  OFS_LENGTH = 4'h8;
  localparam logic [3:0]  OFS_FRAMES = 4'hc;

  // control field positions and reset value
  localparam int          CTRL_EXPRESS = 0;
  localparam int          CTRL_CRC_EN  = 1;
  localparam int          CTRL_MASTER  = 2;
  localparam int          CTRL_RESTART = 3;
  localparam logic [2:0]  CTRL_RST     = 3'h0;

  typedef enum logic [3:0] {
    ST_HUNT, ST_LEN, ST_SEP, ST_DATA, ST_CHECK, ST_GAP,
    ST_POST, ST_LENWAIT, ST_STARTUP, ST_DONE, ST_ERR
  } cbp_state_e;

  typedef struct packed {
    logic       master;
    logic       crc_en;
    logic       express;
  } cbp_ctrl_s;

  typedef struct packed {
    logic       done_pin;
    logic       init_pin;
    logic       done;
    logic       full;
    logic       error;
    logic [3:0] state;
  } cbp_status_s;

endpackage

// >>> cbp_crc16.sv
// serial crc-16 ccitt shift register
`timescale 1ns/100ps
module cbp_crc16
  import cbp_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // control
  input  wire logic        clear,
  input  wire logic        en,
  input  wire logic        bit_in,
  // result
  output      logic [15:0] crc
);

  logic [15:0] crc_reg;
  logic [15:0] crc_next;
  logic        fb;

  always_comb begin
    fb       = crc_reg[15] ^ bit_in;
    crc_next = crc_reg;
    if (clear) begin
      crc_next = CRC_INIT;
    end else if (en) begin
      crc_next = {crc_reg[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      crc_reg <= CRC_INIT;
    end else begin
      crc_reg <= crc_next;
    end
  end

  assign crc = crc_reg;

endmodule

// >>> cbp_parser.sv
// configuration stream parser and checker, serial and express modes
// Operation
// - header: ones, preamble, 24-bit length, separator; express uses 24 fill bits
// - preamble 0010b serial, 11110010b express, then capture length count
// - frame is start field, data bits, check field; start 0b or 11111110b
// - serial postamble 01111111b after last frame; none in express mode
// - four start-up clocks follow data; their values are ignored
// - express ignores length count; start-up begins once all frames arrive, done rises four clocks later
// - express allows only constant-field check; serial selects crc or constant
// - constant check field must be 0110b serial or 11010010b express
// - crc mode compares running crc with four check bits per frame
// - last frame compares eleven bits: four check plus last seven data
// - frame error halts loading, drives wait/error line low, waits
// - clock master keeps driving configuration clock after an error
// - readback appends 11 msbs of crc-16 ccitt checksum
// - extra leading ones and, crc off, trailing ones are accepted
// - serial bits leftmost first; express leftmost bit on line 0
// - serial frame holds one start bit and four check bits plus data
// - serial daisy output high from separator until frames done, then follows
// - serial start-up only when full and clock count equals length
`timescale 1ns/100ps
module cbp_parser
  import cbp_pkg::*;
#(
  parameter int FRAME_DATA      = 121,
  parameter int NUM_FRAMES      = 428,
  parameter int EXP_FRAME_BYTES = 16
)(
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  // register port
  input  wire logic [3:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output      logic [31:0] RDATA,
  // configuration link pins
  input  wire logic        CONFIG_CLOCK_I,
  output      logic        CONFIG_CLOCK_O,
  output      logic        CONFIG_CLOCK_OE,
  input  wire logic        SERIAL_DATA,
  input  wire logic [7:0]  PARALLEL_CONFIG_BYTES,
  input  wire logic        CHAIN_SELECT,
  input  wire logic        RECONFIG_N,
  output      logic        DAISY_OUT,
  // open-drain status pins
  input  wire logic        INIT_I,
  output      logic        INIT_O,
  output      logic        INIT_OE,
  input  wire logic        DONE_I,
  output      logic        DONE_O,
  output      logic        DONE_OE,
  // readback stream
  input  wire logic        RB_BIT,
  input  wire logic        RB_VLD,
  input  wire logic        RB_END,
  output      logic        RB_OUT,
  output      logic        RB_OUT_VLD
);

  if (FRAME_DATA < LAST_DATA_BITS + 1 || FRAME_DATA > 65535) $error("FRAME_DATA out of range");
  if (NUM_FRAMES < 1 || NUM_FRAMES > 65535) $error("NUM_FRAMES out of range");
  if (EXP_FRAME_BYTES < 1 || EXP_FRAME_BYTES > 65535) $error("EXP_FRAME_BYTES out of range");

  localparam logic [15:0] FD_LAST    = 16'(FRAME_DATA - 1);
  localparam logic [15:0] FD_TAIL    = 16'(FRAME_DATA - LAST_DATA_BITS);
  localparam logic [15:0] NF_LAST    = 16'(NUM_FRAMES - 1);
  localparam logic [15:0] EB_LAST    = 16'(EXP_FRAME_BYTES - 1);
  localparam logic [7:0]  HALF_LAST  = 8'(CFG_HALF_CYC - 1);

  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      rev8[7 - i] = v[i];
    end
  endfunction

  // pin synchronisers: clock, data, bytes, select, reconfig, init, done
  logic [13:0] sync1_reg;
  logic [13:0] sync2_reg;
  logic        clk_prev_reg;
  logic        s_clk, s_din, s_cs, s_recfg_n, s_init, s_done;
  logic [7:0]  s_bytes;
  logic        rise, fall;

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      sync1_reg    <= 14'h0000;
      sync2_reg    <= 14'h0000;
      clk_prev_reg <= 1'b0;
    end else begin
      sync1_reg    <= {DONE_I, INIT_I, RECONFIG_N, CHAIN_SELECT, PARALLEL_CONFIG_BYTES, SERIAL_DATA, CONFIG_CLOCK_I};
      sync2_reg    <= sync1_reg;
      clk_prev_reg <= sync2_reg[0];
    end
  end

  assign s_clk     = sync2_reg[0];
  assign s_din     = sync2_reg[1];
  assign s_bytes   = sync2_reg[9:2];
  assign s_cs      = sync2_reg[10];
  assign s_recfg_n = sync2_reg[11];
  assign s_init    = sync2_reg[12];
  assign s_done    = sync2_reg[13];
  assign rise      = s_clk & ~clk_prev_reg;
  assign fall      = ~s_clk & clk_prev_reg;

  // registers and software restart
  cbp_ctrl_s   ctrl_reg, ctrl_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        sw_restart;
  logic        restart;

  // parser state
  cbp_state_e  state_reg, state_next;
  logic [7:0]  sh_reg, sh_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [15:0] frames_reg, frames_next;
  logic [23:0] len_reg, len_next;
  logic [23:0] clks_reg, clks_next;
  logic [10:0] tail_reg, tail_next;
  logic [2:0]  su_reg, su_next;
  logic        full_reg, full_next;
  logic        error_reg, error_next;
  logic        done_reg, done_next;
  logic        dout_reg, dout_next;
  logic [15:0] cfg_crc;
  logic        crc_en_bit;
  logic [7:0]  xbyte;
  logic [3:0]  v4;
  logic [7:0]  v8;
  logic        last_frame;
  logic        chk_ok;
  logic        express;

  assign sw_restart = WR && ADDR == OFS_CTRL && WDATA[CTRL_RESTART];
  assign restart    = sw_restart || !s_recfg_n;
  assign express    = ctrl_reg.express;
  assign xbyte      = rev8(s_bytes);
  assign last_frame = frames_reg == NF_LAST;
  assign v4         = {sh_reg[2:0], s_din};
  assign v8         = {sh_reg[6:0], s_din};

  // running crc over serial frame data, tail of last frame held aside
  assign crc_en_bit = rise && !express && ctrl_reg.crc_en && state_reg == ST_DATA
                      && !(last_frame && cnt_reg >= FD_TAIL);

  cbp_crc16 u_cfg_crc (
    .clk    (CORE_CLK),
    .rst_n  (RESET_N),
    .clear  (restart || state_reg == ST_HUNT),
    .en     (crc_en_bit),
    .bit_in (s_din),
    .crc    (cfg_crc)
  );

  always_comb begin
    state_next  = state_reg;
    sh_next     = sh_reg;
    cnt_next    = cnt_reg;
    frames_next = frames_reg;
    len_next    = len_reg;
    clks_next   = clks_reg;
    tail_next   = tail_reg;
    su_next     = su_reg;
    full_next   = full_reg;
    error_next  = error_reg;
    done_next   = done_reg;
    dout_next   = dout_reg;
    chk_ok      = 1'b0;
    if (restart) begin
      state_next  = ST_HUNT;
      sh_next     = 8'hff;
      cnt_next    = 16'h0000;
      frames_next = 16'h0000;
      clks_next   = 24'h000000;
      full_next   = 1'b0;
      error_next  = 1'b0;
      done_next   = 1'b0;
    end else if (rise && express) begin
      case (state_reg)
        ST_HUNT: begin
          if (xbyte == PRE_EXP) begin
            state_next = ST_LEN;
            cnt_next   = 16'h0000;
          end
        end
        ST_LEN: begin
          cnt_next = cnt_reg + 16'h0001;
          if (cnt_reg == EXP_LEN_LAST) begin
            state_next = ST_SEP;
            cnt_next   = 16'h0000;
          end
        end
        ST_SEP: begin
          cnt_next = cnt_reg + 16'h0001;
          if (cnt_reg == EXP_SEP_LAST) begin
            state_next = ST_GAP;
          end
        end
        ST_GAP: begin
          if (s_cs && xbyte == START_EXP) begin
            state_next = ST_DATA;
            cnt_next   = 16'h0000;
          end
        end
        ST_DATA: begin
          if (s_cs) begin
            cnt_next = cnt_reg + 16'h0001;
            if (cnt_reg == EB_LAST) begin
              state_next = ST_CHECK;
            end
          end
        end
        ST_CHECK: begin
          if (s_cs) begin
            if (xbyte != CHK_EXP) begin
              state_next = ST_ERR;
              error_next = 1'b1;
            end else if (last_frame) begin
              frames_next = frames_reg + 16'h0001;
              full_next   = 1'b1;
              state_next  = ST_STARTUP;
              su_next     = 3'h0;
            end else begin
              frames_next = frames_reg + 16'h0001;
              state_next  = ST_GAP;
            end
          end
        end
        ST_STARTUP: begin
          su_next = su_reg + 3'h1;
          if (su_reg == STARTUP_LAST) begin
            state_next = ST_DONE;
            done_next  = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end else if (rise) begin
      if (state_reg != ST_ERR && state_reg != ST_DONE) begin
        clks_next = clks_reg + 24'h000001;
      end
      case (state_reg)
        ST_HUNT: begin
          sh_next = {sh_reg[6:0], s_din};
          if (v4 == PRE_SER) begin
            state_next = ST_LEN;
            cnt_next   = 16'h0000;
          end
        end
        ST_LEN: begin
          len_next = {len_reg[22:0], s_din};
          cnt_next = cnt_reg + 16'h0001;
          if (cnt_reg == LEN_BITS_LAST) begin
            state_next = ST_SEP;
          end
        end
        ST_SEP, ST_GAP: begin
          if (!s_din) begin
            state_next = ST_DATA;
            cnt_next   = 16'h0000;
          end else if (state_reg == ST_GAP && ctrl_reg.crc_en) begin
            state_next = ST_ERR;
            error_next = 1'b1;
          end
        end
        ST_DATA: begin
          cnt_next = cnt_reg + 16'h0001;
          if (cnt_reg >= FD_TAIL) begin
            tail_next = {tail_reg[9:0], s_din};
          end
          if (cnt_reg == FD_LAST) begin
            state_next = ST_CHECK;
            cnt_next   = 16'h0000;
          end
        end
        ST_CHECK: begin
          sh_next   = {sh_reg[6:0], s_din};
          tail_next = {tail_reg[9:0], s_din};
          cnt_next  = cnt_reg + 16'h0001;
          if (cnt_reg == CHK_BITS_LAST) begin
            if (!ctrl_reg.crc_en) begin
              chk_ok = v4 == CHK_SER;
            end else if (last_frame) begin
              chk_ok = {tail_reg[9:0], s_din} == cfg_crc[15:5];
            end else begin
              chk_ok = v4 == cfg_crc[15:12];
            end
            if (!chk_ok) begin
              state_next = ST_ERR;
              error_next = 1'b1;
            end else if (last_frame) begin
              frames_next = frames_reg + 16'h0001;
              full_next   = 1'b1;
              state_next  = ST_POST;
              cnt_next    = 16'h0000;
            end else begin
              frames_next = frames_reg + 16'h0001;
              state_next  = ST_GAP;
            end
          end
        end
        ST_POST: begin
          sh_next  = {sh_reg[6:0], s_din};
          cnt_next = cnt_reg + 16'h0001;
          if (cnt_reg == POST_BITS_LAST) begin
            if (v8 != POST_SER) begin
              state_next = ST_ERR;
              error_next = 1'b1;
            end else if (clks_next == len_reg) begin
              state_next = ST_STARTUP;
              su_next    = 3'h0;
            end else begin
              state_next = ST_LENWAIT;
            end
          end
        end
        ST_LENWAIT: begin
          if (full_reg && clks_next == len_reg) begin
            state_next = ST_STARTUP;
            su_next    = 3'h0;
          end
        end
        ST_STARTUP: begin
          su_next = su_reg + 3'h1;
          if (su_reg == STARTUP_LAST) begin
            state_next = ST_DONE;
            done_next  = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    if (express) begin
      dout_next = full_reg;
    end else if (fall) begin
      dout_next = s_din;
      if (!full_reg && (state_reg == ST_SEP || state_reg == ST_DATA || state_reg == ST_CHECK
                        || state_reg == ST_GAP)) begin
        dout_next = 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      state_reg  <= ST_HUNT;
      sh_reg     <= 8'hff;
      cnt_reg    <= 16'h0000;
      frames_reg <= 16'h0000;
      len_reg    <= 24'h000000;
      clks_reg   <= 24'h000000;
      tail_reg   <= 11'h000;
      su_reg     <= 3'h0;
      full_reg   <= 1'b0;
      error_reg  <= 1'b0;
      done_reg   <= 1'b0;
      dout_reg   <= 1'b1;
    end else begin
      state_reg  <= state_next;
      sh_reg     <= sh_next;
      cnt_reg    <= cnt_next;
      frames_reg <= frames_next;
      len_reg    <= len_next;
      clks_reg   <= clks_next;
      tail_reg   <= tail_next;
      su_reg     <= su_next;
      full_reg   <= full_next;
      error_reg  <= error_next;
      done_reg   <= done_next;
      dout_reg   <= dout_next;
    end
  end

  // master clock divider, runs regardless of parser state
  logic [7:0]  div_reg, div_next;
  logic        cko_reg, cko_next;

  always_comb begin
    div_next = div_reg;
    cko_next = cko_reg;
    if (ctrl_next.master) begin
      div_next = div_reg + 8'h01;
      if (div_reg == HALF_LAST) begin
        div_next = 8'h00;
        cko_next = ~cko_reg;
      end
    end else begin
      div_next = 8'h00;
      cko_next = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      div_reg <= 8'h00;
      cko_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      cko_reg <= cko_next;
    end
  end

  // readback checksum append
  logic [15:0] rb_crc;
  logic        rb_busy_reg, rb_busy_next;
  logic [3:0]  rb_idx_reg, rb_idx_next;
  logic        rbo_reg, rbo_next;
  logic        rbv_reg, rbv_next;

  cbp_crc16 u_rb_crc (
    .clk    (CORE_CLK),
    .rst_n  (RESET_N),
    .clear  (rb_busy_reg && rb_idx_reg == RB_CRC_LAST),
    .en     (RB_VLD && !rb_busy_reg),
    .bit_in (RB_BIT),
    .crc    (rb_crc)
  );

  always_comb begin
    rb_busy_next = rb_busy_reg;
    rb_idx_next  = rb_idx_reg;
    rbo_next     = 1'b0;
    rbv_next     = 1'b0;
    if (rb_busy_reg) begin
      rbo_next    = rb_crc[4'hf - rb_idx_reg];
      rbv_next    = 1'b1;
      rb_idx_next = rb_idx_reg + 4'h1;
      if (rb_idx_reg == RB_CRC_LAST) begin
        rb_busy_next = 1'b0;
        rb_idx_next  = 4'h0;
      end
    end else if (RB_VLD) begin
      rbo_next = RB_BIT;
      rbv_next = 1'b1;
    end else if (RB_END) begin
      rb_busy_next = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      rb_busy_reg <= 1'b0;
      rb_idx_reg  <= 4'h0;
      rbo_reg     <= 1'b0;
      rbv_reg     <= 1'b0;
    end else begin
      rb_busy_reg <= rb_busy_next;
      rb_idx_reg  <= rb_idx_next;
      rbo_reg     <= rbo_next;
      rbv_reg     <= rbv_next;
    end
  end

  // register port
  cbp_status_s status;

  assign status = '{done_pin: s_done, init_pin: s_init, done: done_reg, full: full_reg,
                    error: error_reg, state: state_reg};

  always_comb begin
    ctrl_next  = ctrl_reg;
    rdata_next = 32'h00000000;
    if (WR && ADDR == OFS_CTRL) begin
      ctrl_next.express = WDATA[CTRL_EXPRESS];
      ctrl_next.crc_en  = WDATA[CTRL_CRC_EN] & ~WDATA[CTRL_EXPRESS];
      ctrl_next.master  = WDATA[CTRL_MASTER];
    end
    if (RD) begin
      case (ADDR)
        OFS_CTRL:   rdata_next = {29'h0, ctrl_reg};
        OFS_STATUS: rdata_next = {23'h0, status};
        OFS_LENGTH: rdata_next = {8'h00, len_reg};
        OFS_FRAMES: rdata_next = {16'h0000, frames_reg};
        default:    rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      ctrl_reg  <= CTRL_RST;
      rdata_reg <= 32'h00000000;
    end else begin
      ctrl_reg  <= ctrl_next;
      rdata_reg <= rdata_next;
    end
  end

  // open-drain low drivers and done enable
  logic od_low_reg;
  logic done_oe_reg;

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      od_low_reg  <= 1'b0;
      done_oe_reg <= 1'b1;
    end else begin
      od_low_reg  <= 1'b0;
      done_oe_reg <= ~done_next;
    end
  end

  assign RDATA           = rdata_reg;
  assign CONFIG_CLOCK_O  = cko_reg;
  assign CONFIG_CLOCK_OE = ctrl_reg.master;
  assign DAISY_OUT       = dout_reg;
  assign INIT_O          = od_low_reg;
  assign INIT_OE         = error_reg;
  assign DONE_O          = od_low_reg;
  assign DONE_OE         = done_oe_reg;
  assign RB_OUT          = rbo_reg;
  assign RB_OUT_VLD      = rbv_reg;

endmodule

// >>> cbp_parser_sva.sv
// assertion checker for the configuration stream parser ports
`timescale 1ns/100ps
module cbp_parser_sva
  import cbp_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // restart sources
  input wire logic WR,
  input wire logic RECONFIG_N,
  // link and status pins
  input wire logic CONFIG_CLOCK_O,
  input wire logic CONFIG_CLOCK_OE,
  input wire logic INIT_O,
  input wire logic INIT_OE,
  input wire logic DONE_O,
  input wire logic DONE_OE,
  // readback stream
  input wire logic RB_BIT,
  input wire logic RB_VLD,
  input wire logic RB_END,
  input wire logic RB_OUT,
  input wire logic RB_OUT_VLD
);
  logic [5:0] rcfg_reg;
  logic       wr_reg;
  logic       mclk_reg;
  logic [7:0] hold_reg;
  logic       quiet;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  // restart history and master clock phase length
  always_ff @(posedge CORE_CLK) begin
    rcfg_reg <= {rcfg_reg[4:0], RECONFIG_N};
    wr_reg   <= WR;
    mclk_reg <= CONFIG_CLOCK_O;
    if (!RESET_N || !CONFIG_CLOCK_OE || CONFIG_CLOCK_O != mclk_reg) hold_reg <= 8'h0;
    else hold_reg <= hold_reg + 8'h1;
  end
  assign quiet = (&rcfg_reg) && RECONFIG_N && !WR && !wr_reg;
  sequence s_sum_bits;
    RB_OUT_VLD [*8] ##1 RB_OUT_VLD [*3];
  endsequence
  property p_rb_sum;
    RB_END |=> ##1 s_sum_bits ##1 !RB_OUT_VLD;
  endproperty
  property p_rb_echo;
    RB_VLD |=> RB_OUT_VLD && (RB_OUT == $past(RB_BIT));
  endproperty
  property p_err_not_done;
    INIT_OE |-> DONE_OE;
  endproperty
  property p_err_holds;
    INIT_OE && quiet |=> INIT_OE;
  endproperty
  property p_done_holds;
    !DONE_OE && quiet |=> !DONE_OE;
  endproperty
  property p_mclk_runs;
    CONFIG_CLOCK_OE |-> hold_reg <= CFG_HALF_CYC;
  endproperty
  property p_mclk_off;
    !CONFIG_CLOCK_OE |-> !CONFIG_CLOCK_O;
  endproperty
  property p_od_low;
    !INIT_O && !DONE_O;
  endproperty
  a_rb_sum: assert property (p_rb_sum) else $error("checksum burst length wrong");
  a_rb_echo: assert property (p_rb_echo) else $error("readback echo wrong");
  a_err_not_done: assert property (p_err_not_done) else $error("done with error");
  a_err_holds: assert property (p_err_holds) else $error("error dropped");
  a_done_holds: assert property (p_done_holds) else $error("done dropped");
  a_mclk_runs: assert property (p_mclk_runs) else $error("master clock stuck");
  a_mclk_off: assert property (p_mclk_off) else $error("clock out when not master");
  a_od_low: assert property (p_od_low) else $error("open drain drives high");
endmodule
bind cbp_parser cbp_parser_sva u_sva (.CORE_CLK, .RESET_N, .WR, .RECONFIG_N, .CONFIG_CLOCK_O, .CONFIG_CLOCK_OE,
  .INIT_O, .INIT_OE, .DONE_O, .DONE_OE, .RB_BIT, .RB_VLD, .RB_END, .RB_OUT, .RB_OUT_VLD);

// >>> cbp_src_model.sv
// configuration source model: link clock and data, one unit per clock
`timescale 1ns/100ps
module cbp_src_model (
  // core clock for alignment
  input wire logic  clk,
  // link pins
  output logic      config_clock,
  output logic      ser,
  output logic [7:0] par
);
  initial begin
    config_clock = 1'b0;
    ser  = 1'b1;
    par  = 8'hff;
  end
  // 80 ns unit: setup 20 ns, high 40 ns, low 40 ns
  task automatic put(input logic [7:0] b);
    @(posedge clk);
    #3;
    ser = b[0];
    par = b;
    #20 config_clock = 1'b1;
    #40 config_clock = 1'b0;
    #16;
  endtask
  // released lines show the inverse, clock stands low
  task automatic rel();
    ser = ~ser;
    par = ~par;
  endtask
endmodule

// >>> cbp_parser_tb.sv
// self-checking bench for the configuration stream parser
`timescale 1ns/100ps
module cbp_parser_tb;
  import cbp_pkg::*;
  localparam int FD = 8;
  localparam int NF = 2;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rcfg_n = 1'b1, cs = 1'b1;
  logic        rb_bit = 1'b0, rb_vld = 1'b0, rb_end = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'h10ec, r;
  logic        config_clock_s, config_clock_pin, ser, mclk, mclk_oe, daisy, init_oe, done_oe, rb_out, rb_ov;
  logic [7:0]  par;
  logic [15:0] c;
  int          n_errors = 0, n_checks = 0, cyc = 0;
  cbp_src_model src (.clk(clk), .config_clock(config_clock_s), .ser(ser), .par(par));
  assign config_clock_pin = mclk_oe ? mclk : config_clock_s;
  cbp_parser #(.FRAME_DATA(FD), .NUM_FRAMES(NF), .EXP_FRAME_BYTES(2)) dut (
    .CORE_CLK(clk), .RESET_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .CONFIG_CLOCK_I(config_clock_pin), .CONFIG_CLOCK_O(mclk), .CONFIG_CLOCK_OE(mclk_oe), .SERIAL_DATA(ser),
    .PARALLEL_CONFIG_BYTES(par), .CHAIN_SELECT(cs), .RECONFIG_N(rcfg_n), .DAISY_OUT(daisy),
    .INIT_I(~init_oe), .INIT_O(), .INIT_OE(init_oe), .DONE_I(~done_oe), .DONE_O(), .DONE_OE(done_oe),
    .RB_BIT(rb_bit), .RB_VLD(rb_vld), .RB_END(rb_end), .RB_OUT(rb_out), .RB_OUT_VLD(rb_ov));
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      summarize();
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] step(input logic [15:0] s, input logic b);
    return {s[14:0], 1'b0} ^ ((s[15] ^ b) ? CRC_POLY : 16'h0);
  endfunction
  function automatic logic [7:0] rev(input logic [7:0] b);
    for (int i = 0; i < 8; i++) rev[i] = b[7 - i];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask
  task automatic sbits(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) src.put({7'h0, v[i]});
  endtask
  task automatic ser_run(input logic crc_on, input logic bad);
    logic [15:0] cl;
    logic [3:0]  ck;
    logic        b;
    logic        tail;
    c = CRC_INIT;
    cl = 16'h0;
    sbits(32'h3ff, 10);
    sbits({28'h0, PRE_SER}, 4);
    sbits(32'd76, 24);
    sbits(32'hf, 4);
    for (int f = 0; f < NF; f++) begin
      sbits(32'h0, 1);
      for (int i = 0; i < FD; i++) begin
        tail = crc_on && f == NF - 1 && i > 0;
        if (crc_on && f == NF - 1 && i == 1) cl = c;
        r = rnd();
        b = tail ? cl[16 - i] : r[0];
        if (!tail) c = step(c, b);
        src.put({7'h0, b});
      end
      ck = !crc_on ? CHK_SER : (f < NF - 1 ? c[15:12] : cl[8:5]);
      sbits({28'h0, ck ^ {3'h0, bad}}, 4);
      if (f == 0 && !bad) begin
        repeat (4) @(posedge clk);
        chk({31'h0, daisy}, 32'h1);
      end
    end
    repeat (6) @(posedge clk);
    chk({31'h0, init_oe}, {31'h0, bad});
    if (!bad) begin
      sbits({24'h0, POST_SER}, 8);
      sbits(32'h7, 3);
      repeat (6) @(posedge clk);
      chk({31'h0, done_oe}, 32'h1);
      sbits(32'h1, 1);
      repeat (6) @(posedge clk);
      chk({31'h0, done_oe}, 32'h0);
    end
    src.rel();
  endtask
  initial begin
    logic [7:0] q[$];
    do_reset();
    c = CRC_INIT;
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      @(posedge clk);
      rb_vld <= 1'b1;
      rb_bit <= r[0];
      c = step(c, r[0]);
    end
    @(posedge clk);
    rb_vld <= 1'b0;
    rb_end <= 1'b1;
    @(posedge clk);
    rb_end <= 1'b0;
    @(posedge clk);
    for (int i = 15; i > 4; i--) begin
      @(negedge clk);
      chk({30'h0, rb_ov, rb_out}, {30'h0, 1'b1, c[i]});
    end
    $display("readback test done");
    do_reset();
    ser_run(1'b0, 1'b0);
    rd_reg(OFS_LENGTH, 32'd76);
    rd_reg(OFS_FRAMES, NF);
    rd_reg(OFS_STATUS, 32'h1e9);
    wr_reg(4'h2, 32'hffff);
    rd_reg(4'h2, 32'h0);
    $display("serial constant test done");
    for (int k = 0; k < 2; k++) begin
      do_reset();
      wr_reg(OFS_CTRL, 32'h2);
      ser_run(1'b1, k[0]);
    end
    $display("serial crc tests done");
    do_reset();
    ser_run(1'b0, 1'b1);
    wr_reg(OFS_CTRL, 32'h4);
    repeat (40) @(posedge clk);
    chk({30'h0, mclk_oe, init_oe}, 32'h3);
    rcfg_n <= 1'b0;
    repeat (4) @(posedge clk);
    rcfg_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk({31'h0, init_oe}, 32'h0);
    $display("error restart test done");
    do_reset();
    wr_reg(OFS_CTRL, 32'h3);
    rd_reg(OFS_CTRL, 32'h1);
    r = rnd();
    q = {8'hff, PRE_EXP, r[7:0], r[15:8], r[23:16], 8'hff, 8'hff, 8'hff};
    q = {q, START_EXP, 8'h0, 8'h0, 8'h0};
    for (int f = 0; f < NF; f++) begin
      r = rnd();
      q = {q, START_EXP, r[7:0], r[15:8], CHK_EXP};
    end
    q = {q, 8'hff, 8'hff, 8'hff, 8'hff};
    foreach (q[i]) begin
      cs <= i < 8 || i > 11;
      src.put(rev(q[i]));
    end
    src.rel();
    repeat (6) @(posedge clk);
    chk({30'h0, daisy, done_oe}, 32'h2);
    $display("express test done");
    summarize();
  end
endmodule
